// [strap_pkg.sv]
// Purpose: Shared constants and types for the strap sampling and pin function block
// Assumes: Pin bit order {test, ac1, ac0, if1, if0} in the captured strap word
// Notes:   Counts are in core clock cycles
package strap_pkg;

	// Operating modes of the serial pins
	typedef enum logic [1:0] {
		MODE_STRAP,
		MODE_SPI_SERVER,
		MODE_SPI_CLIENT,
		MODE_I2C
	} pin_mode_t;

	// Strap word layout
	localparam int STRAP_WIDTH = 5;
	localparam int STRAP_IF0 = 0;
	localparam int STRAP_IF1 = 1;
	localparam int STRAP_AC0 = 2;
	localparam int STRAP_AC1 = 3;
	localparam int STRAP_TEST = 4;

	// Physical pin index in the synchroniser vector
	localparam int PIN_GP0 = 0;
	localparam int PIN_GP1 = 1;
	localparam int PIN_GP2 = 2;
	localparam int PIN_GP3 = 3;
	localparam int PIN_CSN = 4;
	localparam int PIN_SCLK = 5;
	localparam int PIN_MISO = 6;
	localparam int PIN_MOSI = 7;
	localparam int PIN_COUNT = 8;

	// Decodes
	localparam logic [1:0] IF_MODE_SPI = 2'h3;
	localparam logic [1:0] AC_NONE = 2'h0;
	localparam logic [4:0] I2C_ADDR_BASE = 5'h1B;
	localparam logic [1:0] OSC_SEL_XTAL = 2'h1;
	localparam logic [1:0] OSC_SEL_SINGLE = 2'h2;
	localparam int THIRD_CLOCK = 2;

	// Cycles after reset release before straps are taken, covers the synchroniser
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
	// Half period of the server clock in core cycles
	localparam logic [3:0] SERVER_SCLK_HALF = 4'h2;

	// Reset values
	localparam logic [STRAP_WIDTH-1:0] STRAP_RESET = 5'h00;
	localparam logic [3:0] CLOCK_EN_RESET = 4'h0;

endpackage : strap_pkg

// [pin_sync.sv]
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to core_clk_in
// Notes:   No reset, so no pin level is forced into a flop at reset
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input  wire logic             core_clk_in,
	input  wire logic             clk_en_in,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge core_clk_in) begin
		if (clk_en_in) begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : pin_sync

// [strap_pin_ctrl.sv]
// Purpose: Strap capture at reset release and pin function control afterwards
// Assumes: Pin levels are asynchronous; control ports are on core_clk_in
// Notes:   Every pin is an in, out and output-enable triple
//
// How it works
// - Low reset pin clears all state except the pin synchroniser at once, no clock needed.
// - Block stays in reset for as long as the reset pin is low.
// - Auto-config pins sampled at reset release give the configuration selector.
// - After reset, auto-config pins are general pins 0 and 1 under control 1.
// - Test strap high at reset release enters factory test mode.
// - After reset, test pin is general pin 2 under control 2.
// - Third clock positive pin is general pin 3 when that clock is unused.
// - Two interface straps sampled together select the processor interface mode.
// - SPI client drives read data on MISO during reads.
// - SPI server drives chip select and clock toward the EEPROM.
// - SPI server sends on MOSI and captures EEPROM data from MISO.
// - I2C client uses SDA both ways; master supplies SCL.
// - Each input clock has an enable bit; zero disables that input.
// - Source field 01 enables crystal driver, 10 enables single-ended input.
// - Early revision drives MISO low or off during I2C accesses.
// - Every general and serial pin has a disableable output driver.
// - All five strap levels are latched into a status word at release.
// - Interface straps 00, 01, 10 give I2C addresses; 11 gives SPI.
// - External EEPROM, SPI, nonzero selector: server load first, then client.
`timescale 1ns/1ps
module strap_pin_ctrl
	import strap_pkg::*;
#(
	parameter bit EXT_EEPROM = 1'b1,
	parameter bit FIRST_REV  = 1'b0
) (
	// Clock, reset, enable
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       clk_en_in,
	// General pins 0 to 2 and third clock positive pin
	input  wire logic       general_pin_0_in,
	output logic            general_pin_0_out,
	output logic            general_pin_0_oe_out,
	input  wire logic       general_pin_1_in,
	output logic            general_pin_1_out,
	output logic            general_pin_1_oe_out,
	input  wire logic       general_pin_2_in,
	output logic            general_pin_2_out,
	output logic            general_pin_2_oe_out,
	input  wire logic       third_input_pos_in,
	output logic            third_input_pos_out,
	output logic            third_input_pos_oe_out,
	// Serial pins
	input  wire logic       chip_select_n_in,
	output logic            chip_select_n_out,
	output logic            chip_select_n_oe_out,
	input  wire logic       sclk_in,
	output logic            sclk_out,
	output logic            sclk_oe_out,
	input  wire logic       miso_in,
	output logic            miso_out,
	output logic            miso_oe_out,
	input  wire logic       mosi_sda_in,
	output logic            mosi_sda_out,
	output logic            mosi_sda_oe_out,
	// Control bits
	input  wire logic [3:0] general_pin_control_1_in,
	input  wire logic [3:0] general_pin_control_2_in,
	input  wire logic [3:0] input_clock_enable_reg_in,
	input  wire logic [1:0] osc_source_sel_in,
	// Serial engine side
	input  wire logic       client_miso_data_in,
	input  wire logic       client_miso_en_in,
	input  wire logic       server_cs_n_in,
	input  wire logic       server_mosi_in,
	input  wire logic       autoconfig_done_in,
	input  wire logic       i2c_sda_low_in,
	input  wire logic       i2c_busy_in,
	// Status and decoded configuration
	output logic [3:0]      general_pin_state_reg_out,
	output logic [4:0]      strap_capture_reg_out,
	output logic            strap_valid_out,
	output logic [1:0]      auto_config_select_out,
	output logic            test_mode_out,
	output logic [6:0]      i2c_addr_out,
	output logic            spi_server_active_out,
	output logic            spi_client_active_out,
	output logic            i2c_active_out,
	// Clock source enables
	output logic [3:0]      input_clock_enable_bit_out,
	output logic            xtal_driver_en_out,
	output logic            osc_in_a_en_out,
	// Synchronised serial levels and edges for the engine
	output logic            spi_cs_n_out,
	output logic            serial_data_out,
	output logic            eeprom_miso_out,
	output logic            serial_clk_rise_out,
	output logic            serial_clk_fall_out,
	output logic            server_clk_rise_out
);

	// Synchronised pins
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] pin_sync_q;

	assign pin_raw = {mosi_sda_in, miso_in, sclk_in, chip_select_n_in,
		third_input_pos_in, general_pin_2_in, general_pin_1_in, general_pin_0_in};

	pin_sync #(
		.WIDTH (PIN_COUNT)
	) u_pin_sync (
		.core_clk_in (core_clk_in),
		.clk_en_in   (clk_en_in),
		.async_in    (pin_raw),
		.sync_out    (pin_sync_q)
	);

	// Strap capture state
	logic [1:0]             settle_cnt;
	logic [STRAP_WIDTH-1:0] strap;
	logic                   strap_valid;
	pin_mode_t              mode;
	pin_mode_t              next_mode;
	logic [3:0]             sclk_div_cnt;
	logic                   sclk_gen;
	logic                   sclk_prev;

	wire [STRAP_WIDTH-1:0] pin_strap = {pin_sync_q[PIN_GP2], pin_sync_q[PIN_GP1],
		pin_sync_q[PIN_GP0], pin_sync_q[PIN_MISO], pin_sync_q[PIN_CSN]};
	wire capture_now = !strap_valid && (settle_cnt == STRAP_SETTLE_CYCLES);
	wire [1:0] cap_if = pin_strap[STRAP_IF1:STRAP_IF0];
	wire [1:0] cap_ac = pin_strap[STRAP_AC1:STRAP_AC0];
	wire cap_server = EXT_EEPROM && (cap_if == IF_MODE_SPI) && (cap_ac != AC_NONE);

	// Mode selection
	always_comb begin
		next_mode = mode;
		case (mode)
			MODE_STRAP: begin
				if (capture_now) begin
					if (cap_if != IF_MODE_SPI)
						next_mode = MODE_I2C;
					else if (cap_server)
						next_mode = MODE_SPI_SERVER;
					else
						next_mode = MODE_SPI_CLIENT;
				end
			end
			MODE_SPI_SERVER: begin
				if (autoconfig_done_in)
					next_mode = MODE_SPI_CLIENT;
			end
			MODE_SPI_CLIENT: next_mode = MODE_SPI_CLIENT;
			MODE_I2C: next_mode = MODE_I2C;
			default: next_mode = MODE_STRAP;
		endcase
	end

	// Async reset clears everything while the pin is low
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt <= 2'h0;
			strap <= STRAP_RESET;
			strap_valid <= 1'b0;
			mode <= MODE_STRAP;
		end else if (clk_en_in) begin
			if (!strap_valid)
				settle_cnt <= settle_cnt + 2'h1;
			if (capture_now) begin
				strap <= pin_strap;
				strap_valid <= 1'b1;
			end
			mode <= next_mode;
		end
	end

	// Server clock divider, only runs while loading from the EEPROM
	wire server_on = (mode == MODE_SPI_SERVER);
	wire div_wrap = (sclk_div_cnt == SERVER_SCLK_HALF - 4'h1);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sclk_div_cnt <= 4'h0;
			sclk_gen <= 1'b0;
			sclk_prev <= 1'b0;
		end else if (clk_en_in) begin
			sclk_prev <= pin_sync_q[PIN_SCLK];
			if (!server_on) begin
				sclk_div_cnt <= 4'h0;
				sclk_gen <= 1'b0;
			end else if (div_wrap) begin
				sclk_div_cnt <= 4'h0;
				sclk_gen <= !sclk_gen;
			end else begin
				sclk_div_cnt <= sclk_div_cnt + 4'h1;
			end
		end
	end

	// Pin drive decode
	wire gp_on = strap_valid;
	wire gp3_free = !input_clock_enable_reg_in[THIRD_CLOCK];
	wire client_on = (mode == MODE_SPI_CLIENT);
	wire i2c_on = (mode == MODE_I2C);

	wire next_gp0_oe = gp_on && general_pin_control_1_in[1];
	wire next_gp1_oe = gp_on && general_pin_control_1_in[3];
	wire next_gp2_oe = gp_on && general_pin_control_2_in[1];
	wire next_gp3_oe = gp_on && gp3_free && general_pin_control_2_in[3];
	wire next_csn_oe = server_on;
	wire next_sclk_oe = server_on;
	wire client_read = client_on && client_miso_en_in && !pin_sync_q[PIN_CSN];
	wire next_miso_oe = client_read || (FIRST_REV && i2c_on && i2c_busy_in);
	wire next_miso = client_read && client_miso_data_in;
	wire next_mosi_oe = server_on || (i2c_on && i2c_sda_low_in);
	wire next_mosi = server_on && server_mosi_in;
	wire next_srv_rise = server_on && div_wrap && !sclk_gen;

	// Registered pin outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_pin_0_oe_out <= 1'b0;
			general_pin_1_oe_out <= 1'b0;
			general_pin_2_oe_out <= 1'b0;
			third_input_pos_oe_out <= 1'b0;
			general_pin_0_out <= 1'b0;
			general_pin_1_out <= 1'b0;
			general_pin_2_out <= 1'b0;
			third_input_pos_out <= 1'b0;
			chip_select_n_oe_out <= 1'b0;
			chip_select_n_out <= 1'b1;
			sclk_oe_out <= 1'b0;
			sclk_out <= 1'b0;
			miso_oe_out <= 1'b0;
			miso_out <= 1'b0;
			mosi_sda_oe_out <= 1'b0;
			mosi_sda_out <= 1'b0;
		end else if (clk_en_in) begin
			general_pin_0_oe_out <= next_gp0_oe;
			general_pin_1_oe_out <= next_gp1_oe;
			general_pin_2_oe_out <= next_gp2_oe;
			third_input_pos_oe_out <= next_gp3_oe;
			general_pin_0_out <= general_pin_control_1_in[0];
			general_pin_1_out <= general_pin_control_1_in[2];
			general_pin_2_out <= general_pin_control_2_in[0];
			third_input_pos_out <= general_pin_control_2_in[2];
			chip_select_n_oe_out <= next_csn_oe;
			chip_select_n_out <= !server_on || server_cs_n_in;
			sclk_oe_out <= next_sclk_oe;
			sclk_out <= sclk_gen;
			miso_oe_out <= next_miso_oe;
			miso_out <= next_miso;
			mosi_sda_oe_out <= next_mosi_oe;
			mosi_sda_out <= next_mosi;
		end
	end

	// Registered status and engine outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			general_pin_state_reg_out <= 4'h0;
			spi_cs_n_out <= 1'b1;
			serial_data_out <= 1'b1;
			eeprom_miso_out <= 1'b1;
			serial_clk_rise_out <= 1'b0;
			serial_clk_fall_out <= 1'b0;
			server_clk_rise_out <= 1'b0;
		end else if (clk_en_in) begin
			general_pin_state_reg_out <= pin_sync_q[PIN_GP3:PIN_GP0];
			spi_cs_n_out <= !client_on || pin_sync_q[PIN_CSN];
			serial_data_out <= pin_sync_q[PIN_MOSI];
			eeprom_miso_out <= pin_sync_q[PIN_MISO];
			serial_clk_rise_out <= pin_sync_q[PIN_SCLK] && !sclk_prev;
			serial_clk_fall_out <= !pin_sync_q[PIN_SCLK] && sclk_prev;
			server_clk_rise_out <= next_srv_rise;
		end
	end

	// Registered configuration outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_capture_reg_out <= STRAP_RESET;
			strap_valid_out <= 1'b0;
			auto_config_select_out <= 2'h0;
			test_mode_out <= 1'b0;
			i2c_addr_out <= 7'h00;
			spi_server_active_out <= 1'b0;
			spi_client_active_out <= 1'b0;
			i2c_active_out <= 1'b0;
			input_clock_enable_bit_out <= CLOCK_EN_RESET;
			xtal_driver_en_out <= 1'b0;
			osc_in_a_en_out <= 1'b0;
		end else if (clk_en_in) begin
			strap_capture_reg_out <= strap;
			strap_valid_out <= strap_valid;
			auto_config_select_out <= strap[STRAP_AC1:STRAP_AC0];
			test_mode_out <= strap_valid && strap[STRAP_TEST];
			i2c_addr_out <= {I2C_ADDR_BASE, strap[STRAP_IF1:STRAP_IF0]};
			spi_server_active_out <= server_on;
			spi_client_active_out <= client_on;
			i2c_active_out <= i2c_on;
			input_clock_enable_bit_out <= input_clock_enable_reg_in;
			xtal_driver_en_out <= (osc_source_sel_in == OSC_SEL_XTAL);
			osc_in_a_en_out <= (osc_source_sel_in == OSC_SEL_SINGLE);
		end
	end

	// Checks
	a_strap_held: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		strap_valid |=> strap_valid && $stable(strap))
		else $error("strap word changed after capture");
	a_strap_latch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && capture_now |=> strap == $past(pin_strap))
		else $error("strap word not latched from pins");
	a_pins_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		!strap_valid_out |-> !general_pin_0_oe_out && !general_pin_2_oe_out
			&& !miso_oe_out && !chip_select_n_oe_out && !mosi_sda_oe_out)
		else $error("pin driven before straps taken");
	a_mode_decode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && capture_now |=> (mode == MODE_I2C) == ($past(cap_if) != IF_MODE_SPI))
		else $error("interface mode does not follow straps");
	a_server_ends: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && server_on && autoconfig_done_in |=> mode == MODE_SPI_CLIENT)
		else $error("server load did not hand over to client");
	a_server_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && server_on |=> chip_select_n_oe_out && sclk_oe_out && mosi_sda_oe_out)
		else $error("server mode not driving its pins");
	a_gp3_blocked: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && input_clock_enable_reg_in[THIRD_CLOCK] |=> !third_input_pos_oe_out)
		else $error("third clock pin driven while clock in use");
	a_i2c_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		strap_valid_out && $stable(strap_valid_out) |->
			i2c_addr_out == {I2C_ADDR_BASE, strap_capture_reg_out[1:0]})
		else $error("client address mismatch");
	a_xtal_sel: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && osc_source_sel_in == OSC_SEL_XTAL |=> xtal_driver_en_out && !osc_in_a_en_out)
		else $error("crystal driver not enabled");
	a_miso_read: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && client_on && client_miso_en_in && !pin_sync_q[PIN_CSN]
			|=> miso_oe_out && miso_out == $past(client_miso_data_in))
		else $error("client read data not on MISO");
	a_test_mode: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && strap_valid |=> test_mode_out == strap[STRAP_TEST])
		else $error("test mode does not follow strap");
	a_sclk_period: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		clk_en_in && server_on && $rose(sclk_gen) |-> !div_wrap ##1 (sclk_gen || !server_on))
		else $error("server clock half period wrong");

endmodule : strap_pin_ctrl

// [eeprom_model.sv]
// Purpose: Serial EEPROM stand-in on the server side of the serial pins
// Assumes: Data out changes on falling clock, data in taken on rising clock
// Notes:   Data line is released while deselected and then reads as pull-up
`timescale 1ns/1ps
module eeprom_model (
	// Pins
	input  wire logic cs_n_in,
	input  wire logic sclk_in,
	input  wire logic mosi_in,
	output logic      miso_out,
	output logic      miso_oe_out
);
	logic [7:0] tx = 8'h0F;
	logic [7:0] rx = 8'hFF;
	assign miso_oe_out = !cs_n_in;
	assign miso_out    = tx[7];
	always @(negedge cs_n_in) tx = 8'h0F;
	always @(posedge sclk_in) if (!cs_n_in) rx = {rx[6:0], mosi_in};
	always @(negedge sclk_in) if (!cs_n_in) tx = {tx[6:0], tx[7]};
endmodule : eeprom_model

// [strap_pin_ctrl_bench.sv]
// Purpose: Self-checking bench for strap capture and pin function control
// Assumes: Pin levels resolve from every driver's enable; idle serial pins pull up
// Notes:   Expected values queue to a monitor that compares them
`timescale 1ns/1ps
module strap_pin_ctrl_bench
	import strap_pkg::*;
;
	localparam int S = 0, AC = 6, AD = 9, MD = 16, CK = 19, GS = 25, OE = 29, PO = 37;
	localparam logic [34:0] TBL = {5'h02, 5'h14, 5'h03, 5'h01, 5'h00, 5'h00, 5'h00};
	typedef struct {int lsb; int w; logic [15:0] v;} note_t;
	logic        core_clk_in = 1'b0;
	logic        rst_n_in    = 1'b0;
	logic [7:0]  drv         = 8'hF0;
	logic [3:0]  c1 = 4'h0, c2 = 4'h0, ce = 4'h0;
	logic [1:0]  os = 2'h0;
	logic        mdat = 1'b0, men = 1'b0, scs_n = 1'b1, smosi = 1'b1, done = 1'b0;
	logic        sda_lo = 1'b0, eeprom_on = 1'b0;
	logic [31:0] seed = 32'h08F1;
	logic [3:0]  oe_e, st_e;
	wire logic [7:0] oe, po, pin, de;
	wire logic [4:0] strap;
	wire logic [1:0] ac;
	wire logic [6:0] addr;
	wire logic [3:0] cken, gpst;
	wire logic       valid, test, srva, clia, i2ca, xtal, osca, scs, em, rise, e_q, e_oe;
	wire logic       sdat, fall, srise;
	wire logic [49:0] obs;
	int          failures = 0, num_checks = 0, nrise = 0, r0;
	int          nfall = 0, nsrv = 0, r1;
	note_t       q[$];
	note_t       n;
	event        look;
	// Wire levels from all drivers
	assign de  = {drv[7], e_oe ? e_q : drv[6], drv[5:0]};
	assign pin = (oe & po) | (~oe & de);
	assign obs = {srise, fall, sdat, scs, em, po, oe, gpst, osca, xtal, cken, i2ca, clia, srva,
		addr, test, ac,
		valid, strap};
	always #20 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) if (rise === 1'b1) nrise <= nrise + 1;
	always @(posedge core_clk_in) if (fall === 1'b1) nfall <= nfall + 1;
	always @(posedge core_clk_in) if (srise === 1'b1) nsrv <= nsrv + 1;
	strap_pin_ctrl #(.EXT_EEPROM(1'b1), .FIRST_REV(1'b0)) dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
		.general_pin_0_in(pin[0]), .general_pin_0_out(po[0]), .general_pin_0_oe_out(oe[0]),
		.general_pin_1_in(pin[1]), .general_pin_1_out(po[1]), .general_pin_1_oe_out(oe[1]),
		.general_pin_2_in(pin[2]), .general_pin_2_out(po[2]), .general_pin_2_oe_out(oe[2]),
		.third_input_pos_in(pin[3]), .third_input_pos_out(po[3]),
		.third_input_pos_oe_out(oe[3]),
		.chip_select_n_in(pin[4]), .chip_select_n_out(po[4]), .chip_select_n_oe_out(oe[4]),
		.sclk_in(pin[5]), .sclk_out(po[5]), .sclk_oe_out(oe[5]),
		.miso_in(pin[6]), .miso_out(po[6]), .miso_oe_out(oe[6]),
		.mosi_sda_in(pin[7]), .mosi_sda_out(po[7]), .mosi_sda_oe_out(oe[7]),
		.general_pin_control_1_in(c1), .general_pin_control_2_in(c2),
		.input_clock_enable_reg_in(ce), .osc_source_sel_in(os),
		.client_miso_data_in(mdat), .client_miso_en_in(men), .server_cs_n_in(scs_n),
		.server_mosi_in(smosi), .autoconfig_done_in(done), .i2c_sda_low_in(sda_lo),
		.i2c_busy_in(sda_lo), .general_pin_state_reg_out(gpst), .strap_capture_reg_out(strap),
		.strap_valid_out(valid), .auto_config_select_out(ac), .test_mode_out(test),
		.i2c_addr_out(addr), .spi_server_active_out(srva), .spi_client_active_out(clia),
		.i2c_active_out(i2ca), .input_clock_enable_bit_out(cken), .xtal_driver_en_out(xtal),
		.osc_in_a_en_out(osca), .spi_cs_n_out(scs), .serial_data_out(sdat),
		.eeprom_miso_out(em),
		.serial_clk_rise_out(rise), .serial_clk_fall_out(fall), .server_clk_rise_out(srise)
	);
	eeprom_model partner (
		.cs_n_in(pin[4] | ~eeprom_on), .sclk_in(pin[5]), .mosi_in(pin[7]),
		.miso_out(e_q), .miso_oe_out(e_oe)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic chk(input int lsb, input int w, input logic [15:0] v);
		q.push_back('{lsb, w, v});
		-> look;
	endtask : chk
	always begin
		@(look);
		while (q.size() > 0) begin
			n = q.pop_front();
			cmp(16'((obs >> n.lsb) & ((50'h1 << n.w) - 50'h1)), n.v);
		end
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	task automatic do_reset(input logic [4:0] s);
		@(negedge core_clk_in);
		rst_n_in = 1'b0;
		drv[2:0] = s[4:2];
		drv[4]   = s[0];
		drv[6]   = s[1];
		#1;
		chk(OE, 8, 8'h00);
		chk(S + 5, 1, 1'b0);
		repeat (8) @(negedge core_clk_in);
		chk(S + 5, 1, 1'b0);
		rst_n_in = 1'b1;
		repeat (5) @(negedge core_clk_in);
		chk(S, 6, {1'b1, s});
		chk(AC, 3, s[4:2]);
		chk(AD, 7, {I2C_ADDR_BASE, s[1:0]});
		chk(MD, 3, s[1:0] != IF_MODE_SPI ? 3'h4 : (s[3:2] != AC_NONE ? 3'h1 : 3'h2));
		$display("reset test %h done", s);
	endtask : do_reset
	task automatic link(input int k);
		// Let edges from a released clock pin pass before counting
		repeat (4) @(negedge core_clk_in);
		r0 = nrise;
		r1 = nfall;
		#13;
		repeat (k) begin
			drv[5] = 1'b0;
			#160;
			drv[5] = 1'b1;
			#160;
		end
		repeat (4) @(negedge core_clk_in);
		cmp(16'(nrise - r0), 16'(k));
		cmp(16'(nfall - r1), 16'(k));
	endtask : link
	initial begin
		#500us;
		failures++;
		tally_and_finish();
	end
	initial begin
		for (int i = 0; i < 7; i++) begin
			seed = lfsr(seed);
			do_reset(i < 2 ? seed[4:0] : TBL[i * 5 +: 5]);
		end
		sda_lo = 1'b1;
		@(negedge core_clk_in);
		chk(OE + 7, 1, 1'b1);
		chk(PO + 7, 1, 1'b0);
		sda_lo = 1'b0;
		link(2);
		$display("i2c test done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			{drv[3:0], ce, c2, c1} = seed[15:0];
			os = i[1:0];
			@(negedge core_clk_in);
			oe_e = {c2[3] & ~ce[THIRD_CLOCK], c2[1], c1[3], c1[1]};
			st_e = (oe_e & {c2[2], c2[0], c1[2], c1[0]}) | (~oe_e & drv[3:0]);
			chk(OE, 4, oe_e);
			chk(CK, 6, {os == OSC_SEL_SINGLE, os == OSC_SEL_XTAL, ce});
			repeat (3) @(negedge core_clk_in);
			chk(GS, 4, st_e);
			chk(S, 5, 5'h02);
		end
		$display("general pin test done");
		eeprom_on = 1'b1;
		do_reset(5'h07);
		chk(OE + 4, 4, 4'hB);
		r1 = nsrv;
		smosi = 1'b0;
		scs_n = 1'b0;
		repeat (10) @(negedge core_clk_in);
		chk(PO + 4, 1, 1'b0);
		chk(45, 1, 1'b0);
		chk(47, 1, 1'b0);
		repeat (30) @(negedge core_clk_in);
		cmp(16'(partner.rx), 16'h0000);
		cmp(16'(nsrv - r1), 16'(40 / (2 * SERVER_SCLK_HALF)));
		scs_n = 1'b1;
		done  = 1'b1;
		@(negedge core_clk_in);
		done = 1'b0;
		for (int t = 0; clia !== 1'b1; t++) begin
			if (t == 8) begin
				failures++;
				tally_and_finish();
			end
			@(negedge core_clk_in);
		end
		@(negedge core_clk_in);
		chk(MD, 3, 3'h2);
		chk(OE + 4, 2, 2'h0);
		$display("server test done");
		eeprom_on = 1'b0;
		drv[4] = 1'b0;
		link(4);
		men = 1'b1;
		for (int d = 0; d < 2; d++) begin
			mdat = d[0];
			repeat (2) @(negedge core_clk_in);
			chk(OE + 6, 1, 1'b1);
			chk(PO + 6, 1, d[0]);
			chk(46, 1, 1'b0);
		end
		men = 1'b0;
		drv[4] = 1'b1;
		$display("client test done");
		@(negedge core_clk_in);
		tally_and_finish();
	end
endmodule : strap_pin_ctrl_bench
